// ==== hdl/lcd_ctrl_system_reset.sv ====
`timescale 1ns/10ps
// Summary of operation
// - Reset blanks display, stops key scan, clears keys, holds ports low.
// - Display leaves off state only on display-on instruction.
// - Port-state instruction re-enables scanning and releases key data.
// - Port-state instruction releases ports and sets their levels.
// - Reset forces the oscillator to start.
// - Reset clears instruction decode; only later instructions act.
// - Reset clears address counter; valid only after set-address instruction.
// - Display RAMs are not cleared by reset.
// - Display latch loaded when display on/off instruction executes.
// - Reset forces common and segment drivers off.
// - Reset disables contrast until set-contrast instruction.
// - Reset clears key scanner, disables scan, zeroes key data.
// - Reset returns serial interface to idle waiting state.
// - During reset drives low, dual drive pins segment function.
// - During reset scan/port outputs low, dual pins in port function.
// - Data output released in reset and before port-state instruction.
// - Outside reset, pending key read pulls data output low while serial interface is idle.
module lcd_ctrl_system_reset
  import rst_seq_pkg::*;
(
  input  wire logic               CORE_CLK,
  input  wire logic               NRST,
  // Wishbone classic slave
  input  wire logic               WB_CYC_I,
  input  wire logic               WB_STB_I,
  input  wire logic               WB_WE_I,
  input  wire logic [7:0]         WB_ADR_I,
  input  wire logic [3:0]         WB_SEL_I,
  input  wire logic [31:0]        WB_DAT_I,
  output logic      [31:0]        WB_DAT_O,
  output logic                    WB_ACK_O,
  // Asynchronous pins
  input  wire logic               INHIBIT_INPUT_N,
  input  wire logic               SERIAL_CLK,
  input  wire logic               KEY_PRESS,
  // Driver side
  output logic                    OSC_EN,
  output logic                    DISPLAY_ON,
  output logic                    LATCH_LOAD,
  output logic                    DUAL_COM_SEL,
  output logic                    CONTRAST_EN,
  output logic      [CONTR_W-1:0] CONTRAST,
  output logic      [ACNT_W-1:0]  ADDR_COUNTER_VALUE,
  output logic                    SCAN_OR_PORT_OUT_A,
  output logic                    SCAN_OR_PORT_OUT_B,
  output logic      [3:0]         SCAN_OUTPUTS_HI,
  output logic                    SCAN_A_IS_SCAN,
  output logic                    SCAN_B_IS_SCAN,
  output logic                    SERIAL_DATA_OUT,
  output logic                    SERIAL_DATA_OE,
  output logic                    SERIAL_IDLE
);

  // ------------------------------------------------------------
  // Synchronised pins
  // ------------------------------------------------------------
  logic inhibit_n_s;
  logic sclk_s;
  logic key_s;
  logic osc_ready;

  sync2 u_sync_inhibit (.CORE_CLK(CORE_CLK), .NRST(NRST), .d(INHIBIT_INPUT_N), .q(inhibit_n_s));
  sync2 u_sync_clk (.CORE_CLK(CORE_CLK), .NRST(NRST), .d(SERIAL_CLK),      .q(sclk_s));
  sync2 u_sync_key (.CORE_CLK(CORE_CLK), .NRST(NRST), .d(KEY_PRESS),       .q(key_s));

  osc_starter u_osc (
    .CORE_CLK  (CORE_CLK),
    .NRST      (NRST),
    .osc_en    (OSC_EN),
    .osc_ready (osc_ready)
  );

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  wire       req       = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  wire       wr_lo     = req & WB_WE_I & WB_SEL_I[0];
  wire       hit_cmd   = (WB_ADR_I == CMD_OFF);
  wire       hit_arg   = (WB_ADR_I == ARG_OFF);
  wire       hit_stat  = (WB_ADR_I == STATUS_OFF);
  wire       hit_key   = (WB_ADR_I == KEY_OFF);
  wire       hit_acnt  = (WB_ADR_I == ACNT_OFF);
  wire       rd_key    = req & ~WB_WE_I & hit_key;
  wire       cmd_go    = wr_lo & hit_cmd & osc_ready;
  wire [3:0] opcode    = WB_DAT_I[3:0];

  logic [ARG_W-1:0] arg;

  wire op_disp  = cmd_go & (opcode == OP_DISP_ONOFF);
  wire op_tech  = cmd_go & (opcode == OP_SET_TECH);
  wire op_addr  = cmd_go & (opcode == OP_SET_ADDR);
  wire op_contr = cmd_go & (opcode == OP_SET_CONTR);
  wire op_port  = cmd_go & (opcode == OP_PORT_STATE);

  // ------------------------------------------------------------
  // Argument register
  // ------------------------------------------------------------
  // Argument word is staged before the command write
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      arg <= '0;
    end else if (wr_lo & hit_arg) begin
      arg <= WB_DAT_I[ARG_W-1:0];
    end
  end

  // ------------------------------------------------------------
  // Display state
  // ------------------------------------------------------------
  logic disp_on;
  logic dual_com;
  wire  next_disp_on = op_disp ? arg[ARG_DISP_ON_BIT] : disp_on;

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      disp_on  <= 1'b0;
      dual_com <= 1'b0;
    end else begin
      disp_on  <= next_disp_on;
      dual_com <= op_tech ? arg[ARG_DUAL_COM_BIT] : dual_com;
    end
  end

  // drivers off while blanked; inhibit overrides the stored state
  wire  next_drive_on = disp_on & inhibit_n_s;
  assign DUAL_COM_SEL = dual_com;

  // display RAMs sit outside this block; reset clears none of them
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      LATCH_LOAD <= 1'b0;
    end else begin
      LATCH_LOAD <= op_disp;
    end
  end

  // ------------------------------------------------------------
  // Contrast and address counter
  // ------------------------------------------------------------
  logic addr_ok;

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      CONTRAST_EN <= 1'b0;
      CONTRAST    <= '0;
    end else if (op_contr) begin
      CONTRAST_EN <= 1'b1;
      CONTRAST    <= arg[CONTR_W-1:0];
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      ADDR_COUNTER_VALUE <= '0;
      addr_ok            <= 1'b0;
    end else if (op_addr) begin
      ADDR_COUNTER_VALUE <= arg[ACNT_W-1:0];
      addr_ok            <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Key scan and port state
  // ------------------------------------------------------------
  logic             ports_rel;
  logic             kp_a;
  logic             kp_b;
  logic             pc_a;
  logic             pc_b;
  logic [5:0]       kc;
  logic [KEY_W-1:0] key_data;
  logic             key_req;
  logic             key_prev;

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      ports_rel <= 1'b0;
      kp_a      <= 1'b0;
      kp_b      <= 1'b0;
      pc_a      <= 1'b0;
      pc_b      <= 1'b0;
      kc        <= '0;
    end else if (op_port) begin
      ports_rel <= 1'b1;
      kp_a      <= arg[ARG_KP_A_BIT];
      kp_b      <= arg[ARG_KP_B_BIT];
      pc_a      <= arg[ARG_PC_A_BIT];
      pc_b      <= arg[ARG_PC_B_BIT];
      kc        <= arg[ARG_KC_LO +: 6];
    end
  end

  // outputs low, port function until released
  wire       hold_low     = ~ports_rel | ~inhibit_n_s;
  wire       next_a_scan  = ports_rel & kp_a;
  wire       next_b_scan  = ports_rel & kp_b;
  wire       next_out_a   = ~hold_low & (kp_a ? kc[0] : pc_a);
  wire       next_out_b   = ~hold_low & (kp_b ? kc[1] : pc_b);
  wire [3:0] next_scan_hi = hold_low ? 4'h0 : kc[5:2];

  // ------------------------------------------------------------
  // Pin registers
  // ------------------------------------------------------------
  // pins low in reset
  // One cycle of latency is traded for drives that never glitch on decode
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      DISPLAY_ON         <= 1'b0;
      SCAN_A_IS_SCAN     <= 1'b0;
      SCAN_B_IS_SCAN     <= 1'b0;
      SCAN_OR_PORT_OUT_A <= 1'b0;
      SCAN_OR_PORT_OUT_B <= 1'b0;
      SCAN_OUTPUTS_HI    <= 4'h0;
    end else begin
      DISPLAY_ON         <= next_drive_on;
      SCAN_A_IS_SCAN     <= next_a_scan;
      SCAN_B_IS_SCAN     <= next_b_scan;
      SCAN_OR_PORT_OUT_A <= next_out_a;
      SCAN_OR_PORT_OUT_B <= next_out_b;
      SCAN_OUTPUTS_HI    <= next_scan_hi;
    end
  end

  // Key capture: a new press latches the scan lines that are high
  wire key_rise = key_s & ~key_prev;
  wire scan_en  = ports_rel & inhibit_n_s;
  wire [KEY_W-1:0] key_cap = {{(KEY_W-6){1'b0}}, kc};

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      key_prev <= 1'b0;
      key_data <= '0;
      key_req  <= 1'b0;
    end else begin
      key_prev <= key_s;
      if (scan_en & key_rise) begin
        key_data <= key_cap;
        key_req  <= 1'b1;        // Set wins over read clear
      end else if (rd_key) begin
        key_req  <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Serial interface
  // ------------------------------------------------------------
  logic sclk_prev;
  logic serial_busy;

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      sclk_prev   <= 1'b0;
      serial_busy <= 1'b0;
    end else begin
      sclk_prev   <= sclk_s;
      serial_busy <= (sclk_s != sclk_prev) ? 1'b1 : (cmd_go ? 1'b0 : serial_busy);
    end
  end
  assign SERIAL_IDLE = ~serial_busy;

  // released in reset and before release
  assign SERIAL_DATA_OUT = 1'b0;
  assign SERIAL_DATA_OE  = key_req & ports_rel & ~serial_busy;

  // ------------------------------------------------------------
  // Read back and acknowledge
  // ------------------------------------------------------------
  wire [7:0] status = {key_req, osc_ready, dual_com, addr_ok,
                       CONTRAST_EN, ports_rel, scan_en, DISPLAY_ON};
  wire [31:0] rd_mux = hit_arg  ? {{(32-ARG_W){1'b0}}, arg} :
                       hit_stat ? {24'h000000, status} :
                       hit_key  ? {{(32-KEY_W){1'b0}}, key_data} :
                       hit_acnt ? {{(32-ACNT_W){1'b0}}, ADDR_COUNTER_VALUE} :
                       32'h00000000;

  // Single-cycle ack for every address; unmapped reads return zero
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= '0;
    end else begin
      WB_ACK_O <= req;
      WB_DAT_O <= rd_mux;
    end
  end

endmodule : lcd_ctrl_system_reset

// ==== hdl/osc_starter.sv ====
`timescale 1ns/10ps
// Forces the base oscillator on after reset and reports when it is stable
module osc_starter
  import rst_seq_pkg::*;
(
  input  wire logic CORE_CLK,
  input  wire logic NRST,
  output logic      osc_en,
  output logic      osc_ready
);
  osc_state_t state;
  osc_state_t next_state;
  logic [15:0] cnt;
  logic [15:0] next_cnt;
  wire         cnt_done = (cnt == 16'(OSC_START_CYC - 1));

  // ------------------------------------------------------------
  // Start sequence
  // ------------------------------------------------------------
  // forced oscillator start
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    unique case (state)
      OSC_IDLE: begin
        next_state = OSC_WAIT;
        next_cnt   = 16'h0000;
      end
      OSC_WAIT: begin
        next_cnt = cnt + 16'h0001;
        if (cnt_done) begin
          next_state = OSC_RUN;
        end
      end
      OSC_RUN: begin
        next_state = OSC_RUN;
      end
      default: begin
        next_state = OSC_IDLE;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      state <= OSC_IDLE;
      cnt   <= 16'h0000;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  // Enable held on even during reset so the clock is never stopped
  assign osc_en    = 1'b1;
  assign osc_ready = (state == OSC_RUN);
endmodule : osc_starter

// ==== hdl/sync2.sv ====
`timescale 1ns/10ps
// Two-flop synchroniser for a level from outside the clock domain
module sync2 (
  input  wire logic CORE_CLK,
  input  wire logic NRST,
  input  wire logic d,
  output logic      q
);
  logic meta;

  // ------------------------------------------------------------
  // Stages
  // ------------------------------------------------------------
  // First stage is read only by the second
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      meta <= 1'b0;
      q    <= 1'b0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule : sync2

// ==== include/rst_seq_pkg.sv ====
package rst_seq_pkg;

  // ------------------------------------------------------------
  // Register map (byte addresses, one aligned word each)
  // ------------------------------------------------------------
  localparam logic [7:0] CMD_OFF    = 8'h00;  // Instruction issue (write)
  localparam logic [7:0] ARG_OFF    = 8'h04;  // Instruction argument (write/read)
  localparam logic [7:0] STATUS_OFF = 8'h08;  // Sequencer status (read)
  localparam logic [7:0] KEY_OFF    = 8'h0C;  // Key data (read, read acknowledges)
  localparam logic [7:0] ACNT_OFF   = 8'h10;  // Address counter (read)

  // ------------------------------------------------------------
  // Instruction codes written to the command register
  // ------------------------------------------------------------
  localparam logic [3:0] OP_DISP_ONOFF  = 4'h1;
  localparam logic [3:0] OP_SET_TECH    = 4'h2;
  localparam logic [3:0] OP_SET_ADDR    = 4'h3;
  localparam logic [3:0] OP_SET_CONTR   = 4'h4;
  localparam logic [3:0] OP_PORT_STATE  = 4'h5;

  // ------------------------------------------------------------
  // Argument field positions
  // ------------------------------------------------------------
  localparam int ARG_DISP_ON_BIT  = 0;   // Display on/off: 1 = on
  localparam int ARG_DUAL_COM_BIT = 0;   // Technique: 1 = dual pins are commons
  localparam int ARG_KP_A_BIT     = 0;   // Port state: pin a is scan output
  localparam int ARG_KP_B_BIT     = 1;   // Port state: pin b is scan output
  localparam int ARG_PC_A_BIT     = 2;   // Port level of pin a
  localparam int ARG_PC_B_BIT     = 3;   // Port level of pin b
  localparam int ARG_KC_LO        = 4;   // Scan line enables start here
  localparam int ACNT_W           = 6;
  localparam int CONTR_W          = 4;
  localparam int KEY_W            = 30;
  localparam int ARG_W            = 12;

  // Status bit positions
  localparam int ST_DISP_ON  = 0;
  localparam int ST_SCAN_EN  = 1;
  localparam int ST_PORT_REL = 2;
  localparam int ST_CONTR_EN = 3;
  localparam int ST_ADDR_OK  = 4;
  localparam int ST_DUAL_COM = 5;
  localparam int ST_OSC_RUN  = 6;
  localparam int ST_KEY_REQ  = 7;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_HZ          = 20_000_000;
  localparam int OSC_START_NS    = 500;  // Oscillator start settle after reset
  localparam int OSC_START_CYC   = (OSC_START_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  typedef enum logic [2:0] {
    OSC_IDLE = 3'b001,
    OSC_WAIT = 3'b010,
    OSC_RUN  = 3'b100
  } osc_state_t;

endpackage : rst_seq_pkg

// ==== tb/host_link_model.sv ====
`timescale 1ns/10ps
// Host end of the serial link
module host_link_model (
  input  wire logic send,
  input  wire logic oe,
  output logic      SERIAL_CLK,
  output wire logic do_line
);
  // Link clock runs only inside a frame and rests low between frames
  initial SERIAL_CLK = 1'b0;
  // Offset from the core clock edge so the sampler never races a link edge
  always @(posedge send) begin
    #10;
    repeat (16) #200 SERIAL_CLK = ~SERIAL_CLK;
  end
  // pull-up release
  // Open-drain line: pull-up wins whenever the device lets go
  assign do_line = oe ? 1'b0 : 1'b1;
endmodule : host_link_model

// ==== tb/rst_seq_assertions.sv ====
`timescale 1ns/10ps
module rst_seq_chk
  import rst_seq_pkg::*;
(
  input wire logic        CORE_CLK,
  input wire logic        NRST,
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic        WB_WE_I,
  input wire logic [7:0]  WB_ADR_I,
  input wire logic [3:0]  WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic        WB_ACK_O,
  input wire logic        INHIBIT_INPUT_N,
  input wire logic        OSC_EN,
  input wire logic        DISPLAY_ON,
  input wire logic        LATCH_LOAD,
  input wire logic        DUAL_COM_SEL,
  input wire logic        CONTRAST_EN,
  input wire logic        SCAN_OR_PORT_OUT_A,
  input wire logic        SCAN_OR_PORT_OUT_B,
  input wire logic [3:0]  SCAN_OUTPUTS_HI,
  input wire logic        SERIAL_DATA_OE
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);
  // Taken request, taken command write, and opcodes executed since reset
  logic        take;
  logic        cmd_wr;
  logic        dcmd;
  logic [15:0] done;
  assign take   = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  assign cmd_wr = take && WB_WE_I && WB_SEL_I[0] && (WB_ADR_I == CMD_OFF);
  assign dcmd   = cmd_wr && (WB_DAT_I[3:0] == OP_DISP_ONOFF);
  // Commands before oscillator start are never issued by the bench
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      done <= 16'h0000;
    end else if (cmd_wr) begin
      done[WB_DAT_I[3:0]] <= 1'b1;
    end
  end
  property p_ack; take |=> WB_ACK_O ##1 !WB_ACK_O; endproperty
  a_ack: assert property (p_ack) else $error("ack not a single pulse");
  property p_osc; OSC_EN; endproperty
  a_osc: assert property (p_osc) else $error("oscillator not forced on");
  property p_disp; !done[OP_DISP_ONOFF] |-> !DISPLAY_ON; endproperty
  a_disp: assert property (p_disp) else $error("display on without command");
  property p_latch_after; dcmd |=> ##[0:1] LATCH_LOAD; endproperty
  a_latch_after: assert property (p_latch_after) else $error("latch not loaded");
  property p_latch_cause; LATCH_LOAD |-> $past(dcmd) || $past(dcmd, 2); endproperty
  a_latch_cause: assert property (p_latch_cause) else $error("stray latch load");
  property p_inh; !INHIBIT_INPUT_N [*4] |-> !DISPLAY_ON; endproperty
  a_inh: assert property (p_inh) else $error("inhibit left display on");
  property p_ports;
    !done[OP_PORT_STATE] |-> !SCAN_OR_PORT_OUT_A && !SCAN_OR_PORT_OUT_B && SCAN_OUTPUTS_HI == 4'h0;
  endproperty
  a_ports: assert property (p_ports) else $error("ports not held low");
  property p_do_rel; !done[OP_PORT_STATE] |-> !SERIAL_DATA_OE; endproperty
  a_do_rel: assert property (p_do_rel) else $error("data line pulled early");
  property p_contr; !done[OP_SET_CONTR] |-> !CONTRAST_EN; endproperty
  a_contr: assert property (p_contr) else $error("contrast enabled early");
  property p_dual; !done[OP_SET_TECH] |-> !DUAL_COM_SEL; endproperty
  a_dual: assert property (p_dual) else $error("dual pins left segment mode");
endmodule : rst_seq_chk

bind lcd_ctrl_system_reset rst_seq_chk u_chk (
  .CORE_CLK, .NRST, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I, .WB_SEL_I, .WB_DAT_I,
  .WB_ACK_O, .INHIBIT_INPUT_N, .OSC_EN, .DISPLAY_ON, .LATCH_LOAD, .DUAL_COM_SEL,
  .CONTRAST_EN, .SCAN_OR_PORT_OUT_A, .SCAN_OR_PORT_OUT_B, .SCAN_OUTPUTS_HI, .SERIAL_DATA_OE
);

// ==== tb/testbench.sv ====
`timescale 1ns/10ps
module testbench
  import rst_seq_pkg::*;
;
  logic               CORE_CLK, NRST, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O;
  logic [7:0]         WB_ADR_I;
  logic [3:0]         WB_SEL_I, SCAN_OUTPUTS_HI;
  logic [31:0]        WB_DAT_I, WB_DAT_O, d;
  logic [CONTR_W-1:0] CONTRAST;
  logic [ACNT_W-1:0]  ADDR_COUNTER_VALUE;
  logic               INHIBIT_INPUT_N, SERIAL_CLK, KEY_PRESS, OSC_EN, DISPLAY_ON, LATCH_LOAD;
  logic               DUAL_COM_SEL, CONTRAST_EN, SCAN_OR_PORT_OUT_A, SCAN_OR_PORT_OUT_B;
  logic               SCAN_A_IS_SCAN, SCAN_B_IS_SCAN, SERIAL_DATA_OUT, SERIAL_DATA_OE;
  logic               SERIAL_IDLE, send, do_line;
  logic [25:0]        rst_vec;
  logic [3:0]         pin_vec;
  int                 n_errors, n_tests;
  // --------------------------------------------------
  // Design, host link and clock
  // --------------------------------------------------
  lcd_ctrl_system_reset uut (
    .CORE_CLK, .NRST, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I, .WB_SEL_I, .WB_DAT_I,
    .WB_DAT_O, .WB_ACK_O, .INHIBIT_INPUT_N, .SERIAL_CLK, .KEY_PRESS, .OSC_EN, .DISPLAY_ON,
    .LATCH_LOAD, .DUAL_COM_SEL, .CONTRAST_EN, .CONTRAST, .ADDR_COUNTER_VALUE,
    .SCAN_OR_PORT_OUT_A, .SCAN_OR_PORT_OUT_B, .SCAN_OUTPUTS_HI, .SCAN_A_IS_SCAN,
    .SCAN_B_IS_SCAN, .SERIAL_DATA_OUT, .SERIAL_DATA_OE, .SERIAL_IDLE
  );
  host_link_model u_host (.send(send), .oe(SERIAL_DATA_OE), .SERIAL_CLK, .do_line(do_line));
  always #25 CORE_CLK = ~CORE_CLK;
  // Every output but WB_DAT_O and SERIAL_DATA_OUT in one word; reset leaves only oscillator and serial idle high
  assign rst_vec = {OSC_EN, SERIAL_IDLE, DISPLAY_ON, LATCH_LOAD, DUAL_COM_SEL, CONTRAST_EN,
                    CONTRAST, ADDR_COUNTER_VALUE, SCAN_OR_PORT_OUT_A, SCAN_OR_PORT_OUT_B,
                    SCAN_OUTPUTS_HI, SCAN_A_IS_SCAN, SCAN_B_IS_SCAN, SERIAL_DATA_OE, WB_ACK_O};
  // Port pins and their function selects in one nibble
  assign pin_vec = {SCAN_OR_PORT_OUT_A, SCAN_OR_PORT_OUT_B, SCAN_A_IS_SCAN, SCAN_B_IS_SCAN};
  // --------------------------------------------------
  // Tasks
  // --------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge CORE_CLK);
    #1;
  endtask : tick
  // Classic cycle; request held until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge CORE_CLK);
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I  <= we;
    WB_ADR_I <= a;
    WB_DAT_I <= wd;
    n = 0;
    do begin
      @(posedge CORE_CLK);
      n++;
    end while (WB_ACK_O !== 1'b1 && n < 50);
    d = WB_DAT_O;
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
    WB_WE_I  <= 1'b0;
    chk("bus ack", {31'h0, WB_ACK_O}, 32'h1);
  endtask : wb
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), d, e);
  endtask : rd
  // Argument first, then the opcode, as the command port expects
  task automatic cmd(input logic [3:0] op, input logic [31:0] arg);
    wb(1'b1, ARG_OFF, arg);
    wb(1'b1, CMD_OFF, {28'h0, op});
    tick(2);
  endtask : cmd
  task automatic key_hit();
    @(posedge CORE_CLK);
    KEY_PRESS <= 1'b1;
    tick(4);
    @(posedge CORE_CLK);
    KEY_PRESS <= 1'b0;
    tick(6);
  endtask : key_hit
  task automatic wrap_up();
    $display("errors %0d checks %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up
  // --------------------------------------------------
  // Sequence
  // --------------------------------------------------
  task automatic do_reset();
    @(posedge CORE_CLK);
    NRST <= 1'b0;
    tick(5);
    chk("reset pins", {6'h0, rst_vec}, 32'h0300_0000);
    tick(6);
    @(posedge CORE_CLK);
    NRST <= 1'b1;
    tick(15);
    rd(STATUS_OFF, 32'h40);
  endtask : do_reset
  initial begin
    CORE_CLK = 1'b0;
    NRST = 1'b0;
    {WB_CYC_I, WB_STB_I, WB_WE_I, KEY_PRESS, send} = 5'h00;
    WB_ADR_I = 8'h00;
    WB_SEL_I = 4'hF;
    WB_DAT_I = 32'h0;
    INHIBIT_INPUT_N = 1'b1;
    do_reset();
    rd(KEY_OFF, 32'h0);
    rd(ACNT_OFF, 32'h0);
    rd(8'h14, 32'h0);
    cmd(OP_SET_CONTR, 32'hA);
    chk("contrast", {27'h0, CONTRAST_EN, CONTRAST}, 32'h1A);
    // Writes without the low byte lane are refused, so nothing changes
    WB_SEL_I <= 4'h0;
    cmd(OP_SET_CONTR, 32'h5);
    WB_SEL_I <= 4'hF;
    chk("no lane", {27'h0, CONTRAST_EN, CONTRAST}, 32'h1A);
    rd(STATUS_OFF, 32'h48);
    // Key before port setup must not pull the line
    key_hit();
    chk("early key", {31'h0, do_line}, 32'h1);
    rd(KEY_OFF, 32'h0);
    cmd(OP_PORT_STATE, 32'h3F6);
    chk("port pins", pin_vec, 4'b1101);
    chk("scan hi", SCAN_OUTPUTS_HI, 4'hF);
    rd(STATUS_OFF, 32'h4E);
    key_hit();
    chk("key request", {30'h0, do_line, SERIAL_DATA_OUT}, 32'h0);
    // A frame in progress releases the line until the next command
    @(posedge CORE_CLK);
    send <= 1'b1;
    tick(8);
    chk("busy", {SERIAL_IDLE, SERIAL_DATA_OE}, 2'b00);
    send <= 1'b0;
    tick(70);
    cmd(OP_SET_TECH, 32'h1);
    chk("dual com", DUAL_COM_SEL, 1'b1);
    rd(STATUS_OFF, 32'hEE);
    rd(KEY_OFF, 32'h3F);
    tick(2);
    chk("read clears", {31'h0, do_line}, 32'h1);
    cmd(OP_SET_ADDR, 32'h2A);
    chk("addr", ADDR_COUNTER_VALUE, 6'h2A);
    chk("disp pre", DISPLAY_ON, 1'b0);
    // technique, address and contrast loaded before display on
    cmd(OP_DISP_ONOFF, 32'h1);
    chk("disp on", DISPLAY_ON, 1'b1);
    @(posedge CORE_CLK);
    INHIBIT_INPUT_N <= 1'b0;
    tick(6);
    chk("inhibit", {DISPLAY_ON, SCAN_OR_PORT_OUT_A}, 2'b00);
    @(posedge CORE_CLK);
    INHIBIT_INPUT_N <= 1'b1;
    tick(6);
    chk("inhibit off", DISPLAY_ON, 1'b1);
    cmd(OP_DISP_ONOFF, 32'h0);
    chk("disp off", DISPLAY_ON, 1'b0);
    // Pin a now scans and pin b is a port driven high
    cmd(OP_PORT_STATE, 32'h59);
    chk("port pins b", pin_vec, 4'b1110);
    chk("scan hi b", SCAN_OUTPUTS_HI, 4'h1);
    key_hit();
    chk("key request b", {31'h0, do_line}, 32'h0);
    rd(KEY_OFF, 32'h05);
    do_reset();
    wrap_up();
  end
  // Whole run is a few hundred cycles; this is far beyond it
  initial begin
    #2_000_000;
    n_errors++;
    $display("MISMATCH watchdog expected finish seen hang");
    wrap_up();
  end
endmodule : testbench
